// ---- logic/fsp_status_core.sv ----
`timescale 1ns/1ps
module fsp_status_core
	import fsp_pkg::*;
#(
	parameter int PROG_CYCLES = fsp_pkg::PROG_CYC,
	parameter int ERASE_CYCLES = fsp_pkg::ERASE_CYC,
	parameter int CHIP_CYCLES = fsp_pkg::CHIP_CYC
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Serial link pins.
	input wire logic chip_select_n,
	input wire logic serial_clock,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe,
	// Write-protect pin.
	input wire logic write_protect_n,
	// Status view.
	output logic [7:0] status_byte
);
	import fsp_pkg::*;

	// ============================================================
	// Reset release and pin sampling.
	logic [1:0] rst_pipe_ff;
	logic rst_sync_n;
	logic [2:0] wp_ff;
	logic wp_level_ff;
	fsp_link_if link ();

	// Release the reset through two flip-flops.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_pipe_ff <= 2'h0;
		end else begin
			rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_pipe_ff[1];

	fsp_pin_sync u_sync (
		.clock(clock),
		.rst_sync_n(rst_sync_n),
		.chip_select_n(chip_select_n),
		.serial_clock(serial_clock),
		.serial_in(serial_in),
		.link(link)
	);

	// Sample the write-protect pin like the link pins.
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			wp_ff <= 3'h7;
			wp_level_ff <= 1'b1;
		end else begin
			wp_ff <= {wp_ff[1:0], write_protect_n};
			if (wp_ff[1] == wp_ff[2]) begin
				wp_level_ff <= wp_ff[2];
			end
		end
	end

	// ============================================================
	// Status state.
	logic busy_ff;
	logic write_enable_latch_ff;
	logic auto_increment_program_ff;
	logic [3:0] protect_level_ff;
	logic protect_lock_ff;
	logic [31:0] busy_cnt_ff;

	assign status_byte = {protect_lock_ff, auto_increment_program_ff, protect_level_ff,
		write_enable_latch_ff, busy_ff};

	// True when the address lies inside the area selected by the low three level bits.
	function automatic logic is_protected(input logic [3:0] lvl, input logic [23:0] addr);
		logic hit;
		hit = 1'b0;
		case (lvl[2:0])
			3'b000: hit = 1'b0;
			3'b001: hit = addr[18:0] >= PROT_BASE_EIGHTH[18:0];
			3'b010: hit = addr[18:0] >= PROT_BASE_QUARTER[18:0];
			3'b011: hit = addr[18:0] >= PROT_BASE_HALF[18:0];
			default: hit = 1'b1;
		endcase
		return hit;
	endfunction : is_protected

	// ============================================================
	// Frame decoder.
	fsp_state_t state_ff;
	logic [7:0] shift_ff;
	logic [2:0] bit_cnt_ff;
	logic [1:0] byte_cnt_ff;
	logic [7:0] opcode_ff;
	logic [23:0] addr_ff;
	logic [7:0] data_ff;
	logic [7:0] out_shift_ff;
	logic out_active_ff;
	logic [7:0] rx_byte;
	logic byte_done;

	assign rx_byte = {shift_ff[6:0], link.din};
	assign byte_done = link.sel && link.rise && (bit_cnt_ff == 3'h7);

	// Bit and byte framing; a new frame restarts the count.
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			shift_ff <= 8'h00;
			bit_cnt_ff <= 3'h0;
		end else if (link.frame_start) begin
			bit_cnt_ff <= 3'h0;
		end else if (link.sel && link.rise) begin
			shift_ff <= rx_byte;
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
		end
	end

	// Command phases; the start or the end of a frame returns the state to FSP_OPCODE.
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_ff <= FSP_OPCODE;
			opcode_ff <= 8'h00;
			addr_ff <= 24'h000000;
			data_ff <= 8'h00;
			byte_cnt_ff <= 2'h0;
		end else if (link.frame_start || link.frame_end) begin
			state_ff <= FSP_OPCODE;
			byte_cnt_ff <= 2'h0;
		end else if (byte_done) begin
			case (state_ff)
				FSP_OPCODE: begin
					// A command refused while busy keeps no opcode, so it cannot run once busy ends.
					opcode_ff <= (busy_ff && rx_byte != OP_STATUS_READ) ? 8'h00 : rx_byte;
					if (rx_byte == OP_STATUS_READ) begin
						state_ff <= FSP_STATUS;
					end else if (busy_ff) begin
						state_ff <= FSP_DONE;
					end else if (rx_byte == OP_STATUS_WRITE) begin
						state_ff <= FSP_DATA;
					end else if (rx_byte == OP_BYTE_PROG || rx_byte == OP_AUTO_PROG || rx_byte == OP_SECTOR_ERASE
						|| rx_byte == OP_BLOCK32_ERASE || rx_byte == OP_BLOCK64_ERASE) begin
						state_ff <= FSP_ADDR;
					end else begin
						state_ff <= FSP_DONE;
					end
				end
				FSP_ADDR: begin
					addr_ff <= {addr_ff[15:0], rx_byte};
					byte_cnt_ff <= byte_cnt_ff + 2'h1;
					if (byte_cnt_ff == 2'h2) begin
						state_ff <= (opcode_ff == OP_BYTE_PROG || opcode_ff == OP_AUTO_PROG) ? FSP_DATA : FSP_DONE;
					end
				end
				FSP_DATA: begin
					data_ff <= rx_byte;
					state_ff <= FSP_DONE;
				end
				FSP_STATUS: state_ff <= FSP_STATUS;
				FSP_DONE: state_ff <= FSP_DONE;
				default: state_ff <= FSP_OPCODE;
			endcase
		end
	end

	// ============================================================
	// Command execution at the frame's end, only after complete cycles.
	logic exec;
	logic is_erase;
	logic is_chip;
	logic allowed;
	assign exec = link.frame_end && (bit_cnt_ff == 3'h0) && !busy_ff;
	assign is_erase = opcode_ff == OP_SECTOR_ERASE || opcode_ff == OP_BLOCK32_ERASE || opcode_ff == OP_BLOCK64_ERASE;
	assign is_chip = opcode_ff == OP_CHIP_ERASE_A || opcode_ff == OP_CHIP_ERASE_B;
	assign allowed = write_enable_latch_ff && !is_protected(protect_level_ff, addr_ff);

	// Write latch, busy timer, auto flag and protection bits.
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			write_enable_latch_ff <= 1'b0;
			busy_ff <= 1'b0;
			busy_cnt_ff <= 32'h0;
			auto_increment_program_ff <= 1'b0;
			protect_level_ff <= PROT_RESET;
			protect_lock_ff <= 1'b0;
		end else begin
			if (busy_ff) begin
				busy_cnt_ff <= busy_cnt_ff - 32'h1;
				if (busy_cnt_ff == 32'h1) begin
					busy_ff <= 1'b0;
				end
			end
			if (exec && state_ff == FSP_DONE && opcode_ff == OP_WRITE_ENABLE) begin
				write_enable_latch_ff <= 1'b1;
			end
			if (exec && state_ff == FSP_DONE && opcode_ff == OP_WRITE_DISABLE) begin
				write_enable_latch_ff <= 1'b0;
				auto_increment_program_ff <= 1'b0;
			end
			if (exec && state_ff == FSP_DONE && opcode_ff == OP_STATUS_WRITE && write_enable_latch_ff) begin
				write_enable_latch_ff <= 1'b0;
				if (wp_level_ff || !protect_lock_ff) begin
					protect_level_ff <= data_ff[BIT_BP3:BIT_BP0];
					protect_lock_ff <= data_ff[BIT_LOCK];
				end
			end
			if (exec && state_ff == FSP_DONE && (opcode_ff == OP_BYTE_PROG || opcode_ff == OP_AUTO_PROG || is_erase)) begin
				if (allowed) begin
					busy_ff <= 1'b1;
					busy_cnt_ff <= is_erase ? ERASE_CYCLES : PROG_CYCLES;
					auto_increment_program_ff <= opcode_ff == OP_AUTO_PROG;
					if (opcode_ff != OP_AUTO_PROG || addr_ff[18:0] == ADDR_TOP[18:0]) begin
						write_enable_latch_ff <= 1'b0;
						auto_increment_program_ff <= 1'b0;
					end
				end
			end
			if (exec && state_ff == FSP_DONE && is_chip) begin
				if (write_enable_latch_ff && protect_level_ff == 4'h0) begin
					busy_ff <= 1'b1;
					busy_cnt_ff <= CHIP_CYCLES;
					write_enable_latch_ff <= 1'b0;
				end
			end
		end
	end

	// ============================================================
	// Status output: loaded at the start of each byte, shifted on falling edges.
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			out_shift_ff <= 8'h00;
			out_active_ff <= 1'b0;
		end else if (!link.sel) begin
			out_active_ff <= 1'b0;
		end else if (byte_done && (state_ff == FSP_STATUS || (state_ff == FSP_OPCODE && rx_byte == OP_STATUS_READ))) begin
			out_shift_ff <= status_byte;
			out_active_ff <= 1'b1;
		end else if (link.fall && out_active_ff && bit_cnt_ff != 3'h0) begin
			out_shift_ff <= {out_shift_ff[6:0], 1'b0};
		end
	end

	// Drive the output pin from the shifter during a status read.
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			serial_out <= 1'b0;
			serial_out_oe <= 1'b0;
		end else begin
			serial_out_oe <= out_active_ff && link.sel;
			if (link.fall && out_active_ff) begin
				serial_out <= (bit_cnt_ff == 3'h0) ? out_shift_ff[7] : out_shift_ff[6];
			end
		end
	end
endmodule : fsp_status_core

// ---- inc/fsp_pkg.sv ----
package fsp_pkg;
	// ============================================================
	// Status bit positions.
	localparam int BIT_BUSY = 0;
	localparam int BIT_WEL = 1;
	localparam int BIT_BP0 = 2;
	localparam int BIT_BP3 = 5;
	localparam int BIT_AUTO = 6;
	localparam int BIT_LOCK = 7;
	// Power-up value of the protection level field.
	localparam logic [3:0] PROT_RESET = 4'h7;
	// ============================================================
	// Instruction codes.
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST_READ = 8'h0B;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
	localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
	localparam logic [7:0] OP_BYTE_PROG = 8'h02;
	localparam logic [7:0] OP_AUTO_PROG = 8'hAD;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	// Address field width and the base of each protected area.
	localparam int ADDR_W = 24;
	localparam logic [23:0] PROT_BASE_EIGHTH = 24'h070000;
	localparam logic [23:0] PROT_BASE_QUARTER = 24'h060000;
	localparam logic [23:0] PROT_BASE_HALF = 24'h040000;
	// Highest array address, last byte of the array.
	localparam logic [23:0] ADDR_TOP = 24'h07FFFF;
	// ============================================================
	// Internal operation times in microseconds and cycle counts at 40 MHz.
	localparam int CLK_MHZ = 40;
	localparam int T_PROG_US = 10;
	localparam int T_ERASE_US = 25000;
	localparam int T_CHIP_US = 50000;
	localparam int PROG_CYC = T_PROG_US * CLK_MHZ;
	localparam int ERASE_CYC = T_ERASE_US * CLK_MHZ;
	localparam int CHIP_CYC = T_CHIP_US * CLK_MHZ;
	// Frame decoder state.
	typedef enum logic [2:0] {
		FSP_OPCODE = 3'b000,
		FSP_ADDR = 3'b001,
		FSP_DATA = 3'b010,
		FSP_STATUS = 3'b011,
		FSP_DONE = 3'b100
	} fsp_state_t;
endpackage : fsp_pkg

// ---- inc/fsp_link_if.sv ----
`timescale 1ns/1ps
// ============================================================
// Synchronised link events between the front end and the decoder.
interface fsp_link_if;
	logic sel;
	logic frame_start;
	logic frame_end;
	logic rise;
	logic fall;
	logic din;
	modport front (output sel, output frame_start, output frame_end, output rise, output fall, output din);
	modport core (input sel, input frame_start, input frame_end, input rise, input fall, input din);
endinterface : fsp_link_if

// ---- logic/fsp_pin_sync.sv ----
`timescale 1ns/1ps
// ============================================================
// Three-stage sampling of the link pins and edge detection.
module fsp_pin_sync (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_sync_n,
	// Pins.
	input wire logic chip_select_n,
	input wire logic serial_clock,
	input wire logic serial_in,
	// Events.
	fsp_link_if.front link
);
	logic [2:0] cs_ff;
	logic [2:0] sck_ff;
	logic [2:0] si_ff;
	logic cs_level_ff;
	logic sck_level_ff;

	// Shift the pins in; a level counts once stages two and three agree.
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cs_ff <= 3'h7;
			sck_ff <= 3'h0;
			si_ff <= 3'h0;
			cs_level_ff <= 1'b1;
			sck_level_ff <= 1'b0;
		end else begin
			cs_ff <= {cs_ff[1:0], chip_select_n};
			sck_ff <= {sck_ff[1:0], serial_clock};
			si_ff <= {si_ff[1:0], serial_in};
			if (cs_ff[1] == cs_ff[2]) begin
				cs_level_ff <= cs_ff[2];
			end
			if (sck_ff[1] == sck_ff[2]) begin
				sck_level_ff <= sck_ff[2];
			end
		end
	end

	// Edge events derived from the filtered levels.
	assign link.sel = !cs_level_ff;
	assign link.frame_start = cs_level_ff && (cs_ff[1] == cs_ff[2]) && !cs_ff[2];
	assign link.frame_end = !cs_level_ff && (cs_ff[1] == cs_ff[2]) && cs_ff[2];
	assign link.rise = !sck_level_ff && (sck_ff[1] == sck_ff[2]) && sck_ff[2];
	assign link.fall = sck_level_ff && (sck_ff[1] == sck_ff[2]) && !sck_ff[2];
	assign link.din = si_ff[2];
endmodule : fsp_pin_sync

// ---- test/fsp_status_core_assertions.sv ----
`timescale 1ns/1ps
// ==========
// Port checks of the status core.
module fsp_status_core_assertions #(
	parameter int PROG_CYCLES = 20,
	parameter int ERASE_CYCLES = 20,
	parameter int CHIP_CYCLES = 20
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Pins and status.
	input wire logic chip_select_n,
	input wire logic serial_out_oe,
	input wire logic write_protect_n,
	input wire logic [7:0] status_byte
);
	int busy_ff;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// Counts how long busy stands.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			busy_ff <= 0;
		else
			busy_ff <= status_byte[0] ? busy_ff + 1 : 0;
	end
	a_reset_value: assert property ($rose(rst_n) |-> status_byte == 8'h1C)
		else $error("status not at power-up value");
	a_oe_release: assert property (chip_select_n [*8] |-> !serial_out_oe)
		else $error("output enabled while deselected");
	a_lock_hold: assert property ((!write_protect_n && status_byte[7]) [*6]
		|=> $stable({status_byte[7], status_byte[5:2]})) else $error("locked bits changed");
	a_prot_at_end: assert property ($changed({status_byte[7], status_byte[5:2]}) |-> chip_select_n)
		else $error("protection changed inside a frame");
	a_latch_rise: assert property ($rose(status_byte[1]) |-> chip_select_n)
		else $error("latch set inside a frame");
	a_busy_start: assert property ($rose(status_byte[0]) |-> chip_select_n && $past(status_byte[1]))
		else $error("busy without latch");
	a_busy_length: assert property ($fell(status_byte[0]) |-> busy_ff inside
		{[PROG_CYCLES - 1:PROG_CYCLES + 1], [ERASE_CYCLES - 1:ERASE_CYCLES + 1], [CHIP_CYCLES - 1:CHIP_CYCLES + 1]})
		else $error("busy length wrong");
	a_latch_drop: assert property ($fell(status_byte[0]) && !status_byte[6] |-> ##[0:2] !status_byte[1])
		else $error("latch kept after operation");
	a_auto_entry: assert property ($rose(status_byte[6]) |-> status_byte[1] && chip_select_n)
		else $error("auto mode without latch");
endmodule : fsp_status_core_assertions
bind fsp_status_core fsp_status_core_assertions #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES),
	.CHIP_CYCLES(CHIP_CYCLES)) chk (.clock(clock), .rst_n(rst_n), .chip_select_n(chip_select_n),
	.serial_out_oe(serial_out_oe), .write_protect_n(write_protect_n), .status_byte(status_byte));

// ---- test/fsp_host_model.sv ----
`timescale 1ns/1ps
// ==========
// Host end of the link: frames, shifts bytes, samples the reply.
module fsp_host_model (
	// Bench clock that paces the link.
	input wire logic clock,
	// Link pins.
	output logic chip_select_n,
	output logic serial_clock,
	output logic serial_in,
	input wire logic serial_out
);
	// Idle link: deselected, clock parked low.
	initial begin
		chip_select_n = 1'h1;
		serial_clock = 1'h0;
		serial_in = 1'h0;
	end
	// Selects the device a few clocks ahead of the first bit.
	task automatic open_frame();
		repeat (5) @(posedge clock);
		chip_select_n <= 1'h0;
		repeat (4) @(posedge clock);
	endtask : open_frame
	// Sends the top n bits of tx; each half period is four clocks, the reply is read as the clock falls.
	task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			serial_in <= tx[i];
			repeat (4) @(posedge clock);
			serial_clock <= 1'h1;
			repeat (4) @(posedge clock);
			rx[i] = serial_out;
			serial_clock <= 1'h0;
		end
	endtask : shift
	// Deselects and, in the same clock, drives the opposite of the last data bit.
	task automatic close_frame();
		repeat (4) @(posedge clock);
		chip_select_n <= 1'h1;
		serial_in <= ~serial_in;
		repeat (12) @(posedge clock);
	endtask : close_frame
endmodule : fsp_host_model

// ---- test/fsp_status_core_bench.sv ----
`timescale 1ns/1ps
// ==========
// Self-checking bench of the status core.
module fsp_status_core_bench;
	import fsp_pkg::*;
	logic clock, rst_n, write_protect_n, chip_select_n, serial_clock, serial_in, serial_out, serial_out_oe;
	logic [7:0] status_byte, exp_st, s0, s1;
	logic [31:0] lfsr_ff;
	logic [23:0] adr [8] = '{24'h0, PROT_BASE_HALF - 24'h1, PROT_BASE_HALF, PROT_BASE_QUARTER - 24'h1,
		PROT_BASE_QUARTER, PROT_BASE_EIGHTH - 24'h1, PROT_BASE_EIGHTH, ADDR_TOP};
	int num_errors, total_checks, cycles;
	// System clock.
	initial begin
		clock = 1'h0;
		forever #12.5 clock = ~clock;
	end
	// Cuts a hang short.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 95000) begin
			num_errors++;
			end_sim();
		end
	end
	fsp_status_core #(.PROG_CYCLES(20), .ERASE_CYCLES(400), .CHIP_CYCLES(20)) uut (.clock(clock), .rst_n(rst_n),
		.chip_select_n(chip_select_n), .serial_clock(serial_clock), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe), .write_protect_n(write_protect_n),
		.status_byte(status_byte));
	fsp_host_model host (.clock(clock), .chip_select_n(chip_select_n), .serial_clock(serial_clock),
		.serial_in(serial_in),
		.serial_out(serial_out));
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk
	task automatic done(input string n);
		$display("test %s finished", n);
	endtask : done
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr_next
	// Whether a program at a is blocked at level lvl.
	function automatic logic prot_hit(input logic [2:0] lvl, input logic [23:0] a);
		case (lvl)
			3'h0: return 1'h0;
			3'h1: return a >= PROT_BASE_EIGHTH;
			3'h2: return a >= PROT_BASE_QUARTER;
			3'h3: return a >= PROT_BASE_HALF;
			default: return 1'h1;
		endcase
	endfunction : prot_hit
	// One frame; the last byte is cut to cut bits.
	task automatic frame(input logic [7:0] q[$], input int cut);
		logic [7:0] r;
		host.open_frame();
		foreach (q[i])
			host.shift(q[i], (i == q.size() - 1) ? cut : 8, r);
		host.close_frame();
	endtask : frame
	// Reads the status twice in one frame and compares with the port.
	task automatic st_chk(input string msg);
		host.open_frame();
		host.shift(OP_STATUS_READ, 8, s0);
		host.shift(8'h00, 8, s0);
		chk(serial_out_oe, 1'h1, msg);
		host.shift(8'h00, 8, s1);
		host.close_frame();
		chk(s0, exp_st, msg);
		chk(s1, exp_st, msg);
		chk(status_byte, exp_st, msg);
		chk(serial_out_oe, 1'h0, msg);
	endtask : st_chk
	task automatic wr_st(input logic [7:0] d);
		frame({OP_WRITE_ENABLE}, 8);
		frame({OP_STATUS_WRITE, d}, 8);
		if (write_protect_n || !exp_st[7]) begin
			exp_st[7] = d[7];
			exp_st[5:2] = d[5:2];
		end
		exp_st[1] = 1'h0;
		st_chk("status write");
	endtask : wr_st
	// Program or erase with the latch set; run tells if it must start.
	task automatic op(input logic [7:0] q[$], input logic run, input string msg);
		frame({OP_WRITE_ENABLE}, 8);
		frame(q, 8);
		chk(status_byte[0], run, msg);
		repeat (40) @(posedge clock);
		if (run)
			chk(status_byte[1], 1'h0, msg);
		frame({OP_WRITE_DISABLE}, 8);
		exp_st[1] = 1'h0;
		chk(status_byte, exp_st, msg);
	endtask : op
	// Main sequence.
	initial begin
		rst_n = 1'h0;
		write_protect_n = 1'h1;
		lfsr_ff = 32'h8797;
		exp_st = 8'h1C;
		repeat (6) @(posedge clock);
		rst_n <= 1'h1;
		repeat (10) @(posedge clock);
		st_chk("power-up");
		frame({OP_WRITE_ENABLE}, 7);
		st_chk("cut enable");
		frame({OP_WRITE_ENABLE}, 8);
		exp_st[1] = 1'h1;
		st_chk("enable");
		frame({OP_STATUS_WRITE, 8'h00}, 5);
		st_chk("cut write");
		frame({OP_WRITE_DISABLE}, 8);
		exp_st[1] = 1'h0;
		st_chk("disable");
		done("framing");
		wr_st(8'h80);
		@(posedge clock);
		write_protect_n <= 1'h0;
		wr_st(8'h1C);
		repeat (12) begin
			lfsr_ff = lfsr_next(lfsr_ff);
			@(posedge clock);
			write_protect_n <= lfsr_ff[9];
			wr_st(lfsr_ff[7:0]);
		end
		@(posedge clock);
		write_protect_n <= 1'h1;
		wr_st(8'h00);
		done("status write");
		frame({OP_BYTE_PROG, 8'h00, 8'h00, 8'h00, 8'h5A}, 8);
		chk(status_byte[0], 1'h0, "no latch");
		for (int l = 0; l < 8; l++) begin
			wr_st({3'h0, l[2:0], 2'h0});
			foreach (adr[k])
				op({OP_BYTE_PROG, adr[k][23:16], adr[k][15:8], adr[k][7:0], lfsr_ff[7:0]},
					!prot_hit(l[2:0], adr[k]), "program");
		end
		for (int c = 0; c < 4; c++) begin
			wr_st(c[1] ? 8'h20 : 8'h00);
			op({c[0] ? OP_CHIP_ERASE_B : OP_CHIP_ERASE_A}, !c[1], "chip erase");
		end
		done("protection");
		wr_st(8'h00);
		frame({OP_WRITE_ENABLE}, 8);
		frame({OP_SECTOR_ERASE, 8'h00, 8'h10, 8'h00}, 8);
		frame({OP_WRITE_ENABLE}, 8);
		host.open_frame();
		host.shift(OP_STATUS_READ, 8, s0);
		host.shift(8'h00, 8, s0);
		host.close_frame();
		chk(s0[0], 1'h1, "busy read");
		repeat (400) @(posedge clock);
		st_chk("erase done");
		frame({OP_WRITE_ENABLE}, 8);
		frame({OP_AUTO_PROG, 8'h00, 8'h00, 8'h00, 8'h11, 8'h22}, 8);
		repeat (40) @(posedge clock);
		exp_st[6] = 1'h1;
		exp_st[1] = 1'h1;
		st_chk("auto mode");
		frame({OP_WRITE_DISABLE}, 8);
		exp_st[6] = 1'h0;
		exp_st[1] = 1'h0;
		st_chk("auto end");
		done("busy and auto");
		end_sim();
	end
endmodule : fsp_status_core_bench
